// ---- hdl/adcm_map.vh ----
// Constants for the converter mode controller: register offsets,
// field positions, reset values and timing counts.
// Assumes a 100 MHz system clock; included by its bare name.
`ifndef ADCM_MAP_VH
`define ADCM_MAP_VH

// ==========================================================
// Register offsets (byte addresses, one 32-bit word each)
`define ADCM_OFS_CONFIG   8'h00
`define ADCM_OFS_CYCLE    8'h04
`define ADCM_OFS_POINTER  8'h08
`define ADCM_OFS_STATUS   8'h0C
`define ADCM_OFS_RESULT   8'h10

// ==========================================================
// Field positions
`define ADCM_CFG_SEL_FIRST   4
`define ADCM_CFG_SEL_SECOND  5
`define ADCM_STS_BUSY        0
`define ADCM_STS_POWERED     1
`define ADCM_STS_HOLD        2
`define ADCM_STS_CHAN        3
`define ADCM_STS_NEW         4
`define ADCM_STS_INVALID     5
`define ADCM_STS_MODE_LO     8
`define ADCM_RES_CHAN        12
`define ADCM_RES_INVALID     13
`define ADCM_RES_NEW         15

// ==========================================================
// Reset values
`define ADCM_RST_CONFIG   8'h00
`define ADCM_RST_CYCLE    3'h0
`define ADCM_RST_CMD      4'h0

// ==========================================================
// Mode codes
`define ADCM_MODE_PIN     2'h0
`define ADCM_MODE_READ    2'h1
`define ADCM_MODE_AUTO    2'h2

// ==========================================================
// Timing: times as printed, counts derived from the clock rate
`define ADCM_CLK_MHZ      100
`define ADCM_PWRUP_NS     1000
`define ADCM_CONV_NS      2000
`define ADCM_PWRUP_CYC    ((`ADCM_PWRUP_NS*`ADCM_CLK_MHZ+999)/1000)
`define ADCM_CONV_CYC     ((`ADCM_CONV_NS*`ADCM_CLK_MHZ+999)/1000)
`define ADCM_CYC_PER_MS   (`ADCM_CLK_MHZ*1000)
`define ADCM_PTR_FALL_WAKE 4'h5

`endif

// ---- hdl/adcm_ctrl.v ----
// Conversion mode control for a two-channel sampling converter.
// Assumes a serial slave engine on the same clock that frames bytes
// and flags the pointer byte, the read-address ack clock and each
// result word it takes; serial clock and data arrive as raw pins.
//
// Function
// - pin rise powers up, fall holds and converts
// - pin conversion ends after 2 us, then shutdown
// - short pin pulse still converts, result flagged invalid
// - both channels: each pin pulse converts next channel
// - low command bits pick none, first, second, both
// - all command bits zero disables read mode
// - read mode wakes on fifth falling clock edge
// - read mode wake plus conversion about 3 us
// - both channels: first read while second converts
// - further read words keep converting selected channels
// - high-speed busy read stretches clock at ack
// - nonzero cycle timer enables periodic conversions
// - automatic mode powers down between timed conversions
// - only zero timer write stops automatic cycling
// - automatic mode loops channels from lowest upward
//
// The strobed register port and the placing of the registers were decided locally.
`timescale 1ns/100ps
`include "adcm_map.vh"

module adcm_ctrl #(
  parameter integer CYC_PER_MS = `ADCM_CYC_PER_MS,
  parameter integer INT1_MS    = 1,
  parameter integer INT2_MS    = 2,
  parameter integer INT3_MS    = 4,
  parameter integer INT4_MS    = 8,
  parameter integer INT5_MS    = 16,
  parameter integer INT6_MS    = 32,
  parameter integer INT7_MS    = 64
) (
  input  wire        clock,
  input  wire        rst,
  input  wire [7:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  input  wire        conversion_start_pin,
  input  wire        scl_in,
  input  wire        sda_in,
  output reg         scl_out,
  output reg         scl_oe_n,
  input  wire        ptr_byte_active,
  input  wire        read_ack_clock,
  input  wire        result_word_start,
  input  wire        hs_mode,
  input  wire [11:0] adc_code,
  output reg         adc_power_on,
  output reg         track_hold,
  output reg         adc_channel,
  output reg         conv_done
);

  // ==========================================================
  // States and derived counts
  localparam [2:0] ST_IDLE  = 3'b001;
  localparam [2:0] ST_PWRUP = 3'b010;
  localparam [2:0] ST_CONV  = 3'b100;
  localparam [15:0] PWRUP_CYC = `ADCM_PWRUP_CYC;
  localparam [15:0] CONV_CYC  = `ADCM_CONV_CYC;

  // ==========================================================
  // Declarations
  reg  [2:0]  pin_sync_r;
  reg  [2:0]  scl_sync_r;
  reg  [2:0]  sda_sync_r;
  reg         pin_lvl_r;
  reg         scl_lvl_r;
  reg  [7:0]  cfg_r;
  reg  [2:0]  cyc_r;
  reg  [3:0]  cmd_r;
  reg  [3:0]  ptr_shift_r;
  reg  [3:0]  fall_cnt_r;
  reg  [2:0]  state_r;
  reg  [2:0]  state_nxt;
  reg  [15:0] tmr_r;
  reg  [15:0] hi_cnt_r;
  reg  [31:0] int_cnt_r;
  reg  [31:0] int_len;
  reg         next_ch_r;
  reg         invalid_r;
  reg  [11:0] result_r;
  reg         res_ch_r;
  reg         res_inv_r;
  reg         res_new_r;
  wire        pin_rise;
  wire        pin_fall;
  wire        scl_rise;
  wire        scl_fall;
  wire        cfg_first;
  wire        cfg_second;
  wire        cyc_wr;
  wire        res_rd;
  wire [1:0]  mode;
  wire [1:0]  sel;
  wire        start_req;
  wire        ptr_wake;
  wire        read_trig;
  wire        auto_trig;
  wire        busy;
  wire        start_ch;

  // ==========================================================
  // Pin synchronisers: three stages, change counted when 2 and 3 agree
  always @(posedge clock) begin
    if (rst) begin
      pin_sync_r <= 3'h0;
      scl_sync_r <= 3'h7;
      sda_sync_r <= 3'h7;
      pin_lvl_r  <= 1'b0;
      scl_lvl_r  <= 1'b1;
    end else begin
      pin_sync_r <= {pin_sync_r[1:0], conversion_start_pin};
      scl_sync_r <= {scl_sync_r[1:0], scl_in};
      sda_sync_r <= {sda_sync_r[1:0], sda_in};
      if (pin_sync_r[1] == pin_sync_r[2])
        pin_lvl_r <= pin_sync_r[2];
      if (scl_sync_r[1] == scl_sync_r[2])
        scl_lvl_r <= scl_sync_r[2];
    end
  end

  // Edges from the filtered levels only, never from stage one
  assign pin_rise = (pin_sync_r[2] == pin_sync_r[1]) &&
                    pin_sync_r[2] && !pin_lvl_r;
  assign pin_fall = (pin_sync_r[2] == pin_sync_r[1]) &&
                    !pin_sync_r[2] && pin_lvl_r;
  assign scl_rise = (scl_sync_r[2] == scl_sync_r[1]) &&
                    scl_sync_r[2] && !scl_lvl_r;
  assign scl_fall = (scl_sync_r[2] == scl_sync_r[1]) &&
                    !scl_sync_r[2] && scl_lvl_r;

  // ==========================================================
  // Mode and channel selection
  assign cfg_first  = cfg_r[`ADCM_CFG_SEL_FIRST];
  assign cfg_second = cfg_r[`ADCM_CFG_SEL_SECOND];
  // Timer beats command bits; all zero leaves the pin in charge
  assign mode = (cyc_r != 3'h0)      ? `ADCM_MODE_AUTO :
                (cmd_r[1:0] != 2'h0) ? `ADCM_MODE_READ :
                                       `ADCM_MODE_PIN;
  // Read mode uses only the two low command bits
  assign sel  = (mode == `ADCM_MODE_READ) ? cmd_r[1:0] :
                {cfg_second, cfg_first};
  // Both selected: take the sequence pointer; else the one chosen
  assign start_ch = (sel == 2'b11) ? next_ch_r : !sel[0];
  assign busy     = (state_r != ST_IDLE);
  assign cyc_wr   = reg_wr && (reg_addr == `ADCM_OFS_CYCLE);
  assign res_rd   = reg_rd && (reg_addr == `ADCM_OFS_RESULT);

  // ==========================================================
  // Pointer byte capture from the raw serial pins
  // Command bits are the first four bits shifted in, MSB first
  always @(posedge clock) begin
    if (rst) begin
      ptr_shift_r <= 4'h0;
      fall_cnt_r  <= 4'h0;
      cmd_r       <= `ADCM_RST_CMD;
    end else if (!ptr_byte_active) begin
      ptr_shift_r <= 4'h0;
      fall_cnt_r  <= 4'h0;
    end else begin
      if (scl_rise && fall_cnt_r < 4'h4)
        ptr_shift_r <= {ptr_shift_r[2:0], sda_sync_r[2]};
      if (scl_fall && fall_cnt_r != 4'hF)
        fall_cnt_r <= fall_cnt_r + 4'h1;
      // Last command bit is in well before the fifth falling edge
      if (scl_fall && fall_cnt_r == 4'h3)
        cmd_r <= ptr_shift_r;
    end
  end

  // Wake on the fifth falling edge when a low command bit is set
  assign ptr_wake = ptr_byte_active && scl_fall &&
                    (fall_cnt_r == `ADCM_PTR_FALL_WAKE - 4'h1) &&
                    (cmd_r[1:0] != 2'h0) &&
                    (cyc_r == 3'h0);

  // A result word taken by the serial engine while idle starts the next one; one taken while busy is dropped
  assign read_trig = (mode == `ADCM_MODE_READ) &&
                     result_word_start && !busy;

  // ==========================================================
  // Automatic cycle interval table and counter
  always @* begin
    int_len = 32'h0000_0000;
    case (cyc_r)
      3'h1:    int_len = INT1_MS * CYC_PER_MS;
      3'h2:    int_len = INT2_MS * CYC_PER_MS;
      3'h3:    int_len = INT3_MS * CYC_PER_MS;
      3'h4:    int_len = INT4_MS * CYC_PER_MS;
      3'h5:    int_len = INT5_MS * CYC_PER_MS;
      3'h6:    int_len = INT6_MS * CYC_PER_MS;
      3'h7:    int_len = INT7_MS * CYC_PER_MS;
      default: int_len = 32'h0000_0000;
    endcase
  end

  // Interval restarts on every write to the timer
  always @(posedge clock) begin
    if (rst || cyc_wr || cyc_r == 3'h0)
      int_cnt_r <= 32'h0000_0000;
    else if (int_cnt_r + 32'h0000_0001 >= int_len)
      int_cnt_r <= 32'h0000_0000;
    else
      int_cnt_r <= int_cnt_r + 32'h0000_0001;
  end

  // A tick that lands on a running conversion is skipped
  assign auto_trig = (mode == `ADCM_MODE_AUTO) && !cyc_wr &&
                     (int_cnt_r + 32'h0000_0001 >= int_len) &&
                     !busy;

  assign start_req = ptr_wake || read_trig || auto_trig;

  // ==========================================================
  // Pin high-time counter for the power-up check
  always @(posedge clock) begin
    if (rst || pin_rise)
      hi_cnt_r <= 16'h0000;
    else if (pin_lvl_r && hi_cnt_r != 16'hFFFF)
      hi_cnt_r <= hi_cnt_r + 16'h0001;
  end

  // ==========================================================
  // Power and conversion sequencer, next state
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if ((mode == `ADCM_MODE_PIN && pin_rise) || start_req)
          state_nxt = ST_PWRUP;
      end
      ST_PWRUP: begin
        if (mode == `ADCM_MODE_PIN) begin
          if (pin_fall)
            state_nxt = ST_CONV;
        end else if (tmr_r + 16'h0001 >= PWRUP_CYC)
          state_nxt = ST_CONV;
      end
      ST_CONV: begin
        if (tmr_r + 16'h0001 >= CONV_CYC)
          state_nxt = ST_IDLE;
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  // Sequencer registers and converter controls
  always @(posedge clock) begin
    if (rst) begin
      state_r      <= ST_IDLE;
      tmr_r        <= 16'h0000;
      invalid_r    <= 1'b0;
      adc_power_on <= 1'b0;
      track_hold   <= 1'b0;
      adc_channel  <= 1'b0;
      conv_done    <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      conv_done <= 1'b0;
      if (state_nxt != state_r)
        tmr_r <= 16'h0000;
      else if (tmr_r != 16'hFFFF)
        tmr_r <= tmr_r + 16'h0001;
      if (state_r == ST_IDLE && state_nxt == ST_PWRUP) begin
        adc_power_on <= 1'b1;
        adc_channel  <= start_ch;
      end
      if (state_r == ST_PWRUP && state_nxt == ST_CONV) begin
        track_hold <= 1'b1;
        // Short high time means the converter was not yet awake
        invalid_r  <= (mode == `ADCM_MODE_PIN) &&
                      (hi_cnt_r <= PWRUP_CYC);
      end
      if (state_r == ST_CONV && state_nxt == ST_IDLE) begin
        adc_power_on <= 1'b0;
        track_hold   <= 1'b0;
        conv_done    <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Channel sequence pointer, lowest channel first
  always @(posedge clock) begin
    if (rst || cyc_wr)
      next_ch_r <= 1'b0;
    else if (state_r == ST_IDLE && state_nxt == ST_PWRUP && sel == 2'b11)
      next_ch_r <= !next_ch_r;
    else if (sel != 2'b11)
      next_ch_r <= 1'b0;
  end

  // ==========================================================
  // Result holding register; new flag set beats a clearing read
  always @(posedge clock) begin
    if (rst) begin
      result_r  <= 12'h000;
      res_ch_r  <= 1'b0;
      res_inv_r <= 1'b0;
      res_new_r <= 1'b0;
    end else if (state_r == ST_CONV && state_nxt == ST_IDLE) begin
      result_r  <= adc_code;
      res_ch_r  <= adc_channel;
      res_inv_r <= invalid_r;
      res_new_r <= 1'b1;
    end else if (res_rd)
      res_new_r <= 1'b0;
  end

  // ==========================================================
  // Clock stretch at the read ack while a conversion runs
  // Only in high-speed mode; slower masters always find it done
  always @(posedge clock) begin
    if (rst) begin
      scl_out  <= 1'b0;
      scl_oe_n <= 1'b1;
    end else begin
      scl_out  <= 1'b0;
      scl_oe_n <= !(hs_mode && read_ack_clock && busy &&
                    mode == `ADCM_MODE_READ);
    end
  end

  // ==========================================================
  // Register writes: channel select and cycle timer
  always @(posedge clock) begin
    if (rst) begin
      cfg_r <= `ADCM_RST_CONFIG;
      cyc_r <= `ADCM_RST_CYCLE;
    end else if (reg_wr) begin
      if (reg_addr == `ADCM_OFS_CONFIG)
        cfg_r <= reg_wdata[7:0];
      // Only a write with the three low bits zero leaves automatic cycling
      if (reg_addr == `ADCM_OFS_CYCLE)
        cyc_r <= reg_wdata[2:0];
    end
  end

  // ==========================================================
  // Register reads: data stand one cycle after the strobe only
  always @(posedge clock) begin
    if (rst || !reg_rd)
      reg_rdata <= 32'h0000_0000;
    else begin
      case (reg_addr)
        `ADCM_OFS_CONFIG:  reg_rdata <= {24'h00_0000, cfg_r};
        `ADCM_OFS_CYCLE:   reg_rdata <= {29'h0000_0000, cyc_r};
        `ADCM_OFS_POINTER: reg_rdata <= {28'h000_0000, cmd_r};
        `ADCM_OFS_STATUS:
          reg_rdata <= {22'h00_0000, mode, 2'h0, invalid_r, res_new_r,
                        adc_channel, track_hold, adc_power_on, busy};
        `ADCM_OFS_RESULT:
          reg_rdata <= {16'h0000, res_new_r, 1'b0, res_inv_r, res_ch_r,
                        result_r};
        default:           reg_rdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule // adcm_ctrl

// ---- testbench/adcm_ctrl_monitor.sv ----
// Checker for the converter mode controller, port level only.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/100ps

module adcm_ctrl_monitor (
  input wire        clock,
  input wire        rst,
  input wire        reg_rd,
  input wire [31:0] reg_rdata,
  input wire        scl_out,
  input wire        scl_oe_n,
  input wire        read_ack_clock,
  input wire        hs_mode,
  input wire        adc_power_on,
  input wire        track_hold,
  input wire        conv_done
);
  // ==========================================================
  // Timing relations between pins
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  chk_hold_power: assert property (track_hold |-> adc_power_on)
    else $error("hold without power");
  chk_conv_length: assert property (
    $rose(track_hold) |-> ##200 (conv_done && !track_hold))
    else $error("conversion length wrong");
  chk_done_off: assert property (
    conv_done |-> !adc_power_on && !track_hold)
    else $error("still powered at done");
  chk_done_pulse: assert property (conv_done |=> !conv_done)
    else $error("done not one cycle");
  chk_hold_end: assert property ($fell(track_hold) |-> conv_done)
    else $error("hold ended without done");
  chk_stretch_cause: assert property (
    !scl_oe_n |-> $past(hs_mode) && $past(read_ack_clock))
    else $error("stretch without cause");
  chk_stretch_busy: assert property (
    !scl_oe_n |-> (adc_power_on || conv_done))
    else $error("stretch while idle");
  chk_stretch_low: assert property (!scl_oe_n |-> !scl_out)
    else $error("stretch drives high");
  chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 0)
    else $error("read data outside slot");
endmodule // adcm_ctrl_monitor

bind adcm_ctrl adcm_ctrl_monitor i_mon (
  .clock(clock), .rst(rst), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .scl_out(scl_out), .scl_oe_n(scl_oe_n), .read_ack_clock(read_ack_clock),
  .hs_mode(hs_mode), .adc_power_on(adc_power_on),
  .track_hold(track_hold), .conv_done(conv_done));

// ---- testbench/adcm_bus_master.sv ----
// Two-wire master model: sends the pointer byte at 80 ns SCL period.
// Assumes the bench reads the line level back through pull-ups.
`timescale 1ns/100ps

module adcm_bus_master #(
  parameter [3:0] RES_PTR = 4'h0
) (
  input wire clock,
  output reg scl,
  output reg sda,
  output reg ptr_act
);
  // ==========================================================
  // Idle bus: both lines released, pulled high
  initial begin
    scl = 1'b1;
    sda = 1'b1;
    ptr_act = 1'b0;
  end

  // Pointer byte, MSB first; clock stands still outside the byte
  task send_ptr(input [3:0] cmd);
    reg [7:0] b;
    integer   j;
    begin
      b = {2'b00, cmd[1:0], RES_PTR};
      scl = 1'b0;
      // Gap keeps the lead-in fall out of the byte's edge count
      repeat (6) @(posedge clock);
      ptr_act <= 1'b1;
      #2;
      for (j = 7; j >= 0; j = j - 1) begin
        sda = b[j];
        #40 scl = 1'b1;
        #40 scl = 1'b0;
      end
      sda = 1'b1;
      repeat (8) @(posedge clock);
      ptr_act <= 1'b0;
      #3 scl = 1'b1;
    end
  endtask
endmodule // adcm_bus_master

// ---- testbench/adc_conversion_mode_control_test.sv ----
// Self-checking bench for the converter mode controller.
// Assumes the design header and the master model compile first.
`timescale 1ns/100ps
`include "adcm_map.vh"

module adc_conversion_mode_control_test;
  reg  [11:0] code;
  reg         clock;
  reg         rst;
  reg         reg_wr;
  reg         reg_rd;
  reg         pin;
  reg         rws;
  reg         hs;
  reg         ack;
  reg  [7:0]  reg_addr;
  reg  [7:0]  a;
  reg  [31:0] reg_wdata;
  reg  [31:0] rd;
  wire [31:0] reg_rdata;
  wire        scl_m, sda, pact, scl_out, scl_oe_n, pwr, hold, chan, done;
  wire        scl_w;
  integer     err_total = 0;
  integer     checks_done = 0;
  integer     cyc = 0;
  integer     k;

  // Wired line: a stretch pulls SCL low over the master
  assign scl_w = scl_oe_n ? scl_m : scl_out;

  adcm_bus_master i_mst (.clock(clock), .scl(scl_m), .sda(sda),
    .ptr_act(pact));

  // Short millisecond keeps the cycle intervals simulable
  adcm_ctrl #(.CYC_PER_MS(100), .INT1_MS(5), .INT7_MS(7)) i_dut (
    .clock(clock), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .conversion_start_pin(pin),
    .scl_in(scl_w), .sda_in(sda), .scl_out(scl_out),
    .scl_oe_n(scl_oe_n), .ptr_byte_active(pact),
    .read_ack_clock(ack), .result_word_start(rws), .hs_mode(hs),
    .adc_code(code), .adc_power_on(pwr), .track_hold(hold),
    .adc_channel(chan), .conv_done(done));

  // ==========================================================
  // Clock and hang guard
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_total = err_total + 1;
      test_done;
    end
  end

  // ==========================================================
  // Shared tasks
  task test_done;
    begin
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask

  task chk(input [31:0] g, input [31:0] e);
    begin
      checks_done = checks_done + 1;
      if (g !== e) begin
        err_total = err_total + 1;
        $display("Error %0t: got %h want %h", $time, g, e);
      end
    end
  endtask

  task reg_write(input [7:0] ad, input [31:0] d);
    begin
      @(posedge clock);
      reg_wr <= 1'b1;
      reg_addr <= ad;
      reg_wdata <= d;
      @(posedge clock);
      reg_wr <= 1'b0;
    end
  endtask

  task reg_read(input [7:0] ad);
    begin
      @(posedge clock);
      reg_rd <= 1'b1;
      reg_addr <= ad;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 rd = reg_rdata;
    end
  endtask

  // Bounded wait for the done pulse; e says whether one is due
  task wait_done(input integer n, input e);
    begin
      k = 0;
      do begin
        @(posedge clock);
        #1 k = k + 1;
      end while (done !== 1'b1 && k < n);
      chk(done, e);
    end
  endtask

  task rcheck(input ch, input inv);
    begin
      reg_read(`ADCM_OFS_RESULT);
      chk(rd, {16'h0000, 2'b10, inv, ch, code});
    end
  endtask

  // ==========================================================
  // Scenarios
  task pin_conv(input integer hi, input ch, input inv);
    begin
      @(posedge clock);
      pin <= 1'b1;
      // A fresh code per conversion proves the result is latched anew
      code <= code + 12'h111;
      repeat (6) @(posedge clock);
      #1 chk(pwr, 1);
      chk(hold, 0);
      chk(chan, ch);
      repeat (hi - 6) @(posedge clock);
      pin <= 1'b0;
      repeat (6) @(posedge clock);
      #1 chk(hold, 1);
      wait_done(300, 1);
      chk(pwr, 0);
      rcheck(ch, inv);
    end
  endtask

  task rws_conv(input ch);
    begin
      @(posedge clock);
      rws <= 1'b1;
      code <= code + 12'h111;
      @(posedge clock);
      rws <= 1'b0;
      wait_done(450, 1);
      rcheck(ch, 0);
    end
  endtask

  task t_reset;
    begin
      // Last address is unmapped and must read zero too
      for (a = 8'h00; a < 8'h18; a = a + 8'h04) begin
        reg_read(a);
        chk(rd, 0);
      end
    end
  endtask

  task t_pin;
    begin
      reg_write(`ADCM_OFS_CONFIG, 32'h0000_0010);
      pin_conv(150, 0, 0);
      pin_conv(50, 0, 1);
      reg_write(`ADCM_OFS_CONFIG, 32'h0000_0030);
      reg_write(`ADCM_OFS_CYCLE, 32'h0000_0000);
      pin_conv(150, 0, 0);
      pin_conv(150, 1, 0);
    end
  endtask

  task t_read;
    begin
      i_mst.send_ptr(4'h1);
      wait_done(450, 1);
      rcheck(0, 0);
      reg_read(`ADCM_OFS_POINTER);
      chk(rd, 1);
      rws_conv(0);
      i_mst.send_ptr(4'h2);
      wait_done(450, 1);
      rcheck(1, 0);
      i_mst.send_ptr(4'h3);
      @(posedge clock);
      hs <= 1'b1;
      ack <= 1'b1;
      repeat (3) @(posedge clock);
      #1 chk(scl_oe_n, 0);
      wait_done(450, 1);
      @(posedge clock);
      #1 chk(scl_oe_n, 1);
      hs <= 1'b0;
      ack <= 1'b0;
      rcheck(0, 0);
      rws_conv(1);
      i_mst.send_ptr(4'h0);
      wait_done(450, 0);
      reg_read(`ADCM_OFS_STATUS);
      chk(rd[9:8], `ADCM_MODE_PIN);
    end
  endtask

  task t_auto;
    begin
      reg_write(`ADCM_OFS_CYCLE, 32'h0000_0001);
      wait_done(900, 1);
      wait_done(600, 1);
      chk(k, 500);
      chk(pwr, 0);
      rcheck(1, 0);
      wait_done(600, 1);
      rcheck(0, 0);
      reg_write(`ADCM_OFS_CYCLE, 32'h0000_0000);
      wait_done(1200, 0);
      // Highest code checks the far end of the interval table
      reg_write(`ADCM_OFS_CYCLE, 32'h0000_0007);
      wait_done(1100, 1);
      wait_done(800, 1);
      chk(k, 700);
      reg_write(`ADCM_OFS_CYCLE, 32'h0000_0000);
      wait_done(900, 0);
    end
  endtask

  // ==========================================================
  // Main sequence; pin stays low outside its own mode
  initial begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    pin = 1'b0;
    rws = 1'b0;
    hs = 1'b0;
    ack = 1'b0;
    code = 12'h5A3;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    t_reset;
    t_pin;
    t_read;
    t_auto;
    test_done;
  end
endmodule // adc_conversion_mode_control_test
